//--- common/mwd_pkg.sv
// Purpose: Shared constants for the monitor mode and watchdog sequencer.
// Assumes: A 250 MHz core clock with a period of 4 ns.
// Notes:   Timing figures are kept in their own unit and turned into cycles here.
package mwd_pkg;

  // Core clock period in picoseconds.
  localparam int unsigned CLOCK_PERIOD_PS = 4000;
  // Watchdog timeout in microseconds, as printed (98.3 ms).
  localparam int unsigned WDOG_TIMEOUT_US = 98300;
  // Watchdog timeout in clock cycles, rounded down as a longest time.
  localparam int unsigned WDOG_TIMEOUT_CYC = (WDOG_TIMEOUT_US * 1000) / (CLOCK_PERIOD_PS / 1000);

  // Fault register address and bit positions.
  localparam logic [5:0] FAULT_REG_ADDR = 6'h01;
  localparam int unsigned FLT_POR_BIT = 7;
  localparam int unsigned FLT_WDOG_BIT = 6;
  localparam int unsigned FLT_LDO_BIT = 5;
  localparam int unsigned FLT_FUSE_BIT = 3;
  localparam int unsigned FLT_DCM_BIT = 2;
  localparam int unsigned FLT_CFG_BIT = 1;
  localparam int unsigned FLT_OSC_BIT = 0;
  // Fault register value after reset: only the power-on flag is set.
  localparam logic [7:0] FAULT_RESET_VALUE = 8'h80;

  // Secondary converter resolution and channel plan.
  localparam int unsigned SEC_ADC_BITS = 10;
  localparam int unsigned SEC_CELL_CHANNELS = 9;
  localparam int unsigned SEC_CHANNELS = 11;
  localparam logic [3:0] SEC_CH_REG5 = 4'h9;
  localparam logic [3:0] SEC_CH_REF1 = 4'hA;
  localparam logic [3:0] SEC_CH_LAST = 4'hA;

  // Life counter width.
  localparam int unsigned LIFE_BITS = 3;

  // Operating modes.
  typedef enum logic [1:0] {
    MWD_ACTIVE,
    MWD_PARTIAL_PD,
    MWD_FULL_PD
  } mwd_mode_type;

endpackage

//--- src/mwd_sequencer.sv
// Purpose: Mode control, communication watchdog and conversion sequencing.
// Assumes: Commands arrive already decoded and CRC-checked from the serial front end.
// Notes:   The analog converters are outside; this block sequences and scores them.
//
// Overview of operation
// - Three modes; measure only while active.
// - Lost communication forces full power-down.
// - Leaving full power-down needs chain re-initialization.
// - Watchdog runs from power-up, 98.3 ms timeout.
// - Diagnostics run at sequence end; life counter.
// - Secondary path: 10-bit, nine cells, REG5 and one reference.
// - Diagnostics reach host only through master.
// - Watchdog expiry sets fault bit six.
// - Sequence end updates fault register flags.
`timescale 1ns/1ns
module mwd_sequencer #(
  parameter int unsigned WDOG_CYCLES = mwd_pkg::WDOG_TIMEOUT_CYC,
  parameter int unsigned CHANNELS    = mwd_pkg::SEC_CHANNELS
) (
  // Clock, reset and clock enable.
  input  wire logic                                 i_clock,
  input  wire logic                                 i_rst_n,
  input  wire logic                                 i_clk_en,
  // Decoded host commands, one-cycle pulses.
  input  wire logic                                 i_wdog_service,
  input  wire logic                                 i_addr_assigned,
  input  wire logic                                 i_conv_request,
  input  wire logic                                 i_partial_pd_request,
  input  wire logic                                 i_wake_request,
  input  wire logic                                 i_fault_read,
  // Secondary converter handshake.
  output logic                                      o_sec_start,
  output logic [3:0]                                o_sec_channel,
  input  wire logic                                 i_sec_done,
  input  wire logic [mwd_pkg::SEC_ADC_BITS-1:0]     i_sec_data,
  // Raw diagnostic levels from the analog monitors.
  input  wire logic                                 i_ldo_out_of_range,
  input  wire logic                                 i_fuse_crc_bad,
  input  wire logic                                 i_chain_cm_bad,
  input  wire logic                                 i_test_mode,
  input  wire logic                                 i_osc_drift,
  // Status towards the serial front end.
  output logic [1:0]                                o_mode,
  output logic                                      o_initialized,
  output logic                                      o_busy,
  output logic [7:0]                                o_fault_reg,
  output logic [mwd_pkg::LIFE_BITS-1:0]             o_life_count,
  output logic [mwd_pkg::SEC_ADC_BITS-1:0]          o_sec_result,
  output logic [3:0]                                o_sec_result_ch,
  output logic                                      o_sec_result_valid
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  // Sequencer phases of one secondary conversion run.
  typedef enum logic [1:0] {
    MWD_SEQ_IDLE,
    MWD_SEQ_START,
    MWD_SEQ_WAIT,
    MWD_SEQ_DIAG
  } mwd_seq_type;

  localparam int unsigned WDW = $clog2(WDOG_CYCLES + 1);

  mwd_pkg::mwd_mode_type         mode_q, mode_d;          // Operating mode.
  mwd_seq_type                   seq_q, seq_d;            // Sequence phase.
  logic [WDW-1:0]                wdog_q, wdog_d;          // Watchdog cycle count.
  logic                          init_q, init_d;          // Chain address set since wake.
  logic [7:0]                    fault_q, fault_d;        // Fault register image.
  logic [mwd_pkg::LIFE_BITS-1:0] life_q, life_d;          // Secondary life counter.
  logic [3:0]                    ch_q, ch_d;              // Channel being converted.
  logic [mwd_pkg::SEC_ADC_BITS-1:0] res_q, res_d;         // Last conversion result.
  logic [3:0]                    res_ch_q, res_ch_d;      // Channel of last result.
  logic                          res_v_q, res_v_d;        // Result strobe.
  logic                          wdog_expired;            // Timeout reached this cycle.

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // Watchdog expires once the count reaches the full timeout; it is idle in full power-down,
  // so the expiry cannot repeat in the first powered-down cycle and swallow a wake command.
  assign wdog_expired = (wdog_q == WDW'(WDOG_CYCLES - 1)) && !i_wdog_service &&
                        (mode_q != mwd_pkg::MWD_FULL_PD);

  // Computes the next mode, watchdog, sequencer and fault state.
  always_comb begin
    mode_d   = mode_q;
    seq_d    = seq_q;
    wdog_d   = wdog_q;
    init_d   = init_q;
    fault_d  = fault_q;
    life_d   = life_q;
    ch_d     = ch_q;
    res_d    = res_q;
    res_ch_d = res_ch_q;
    res_v_d  = 1'b0;

    // Watchdog counts in every mode but full power-down.
    if (mode_q == mwd_pkg::MWD_FULL_PD) begin
      wdog_d = '0;
    end else if (i_wdog_service) begin
      wdog_d = '0;
    end else if (!wdog_expired) begin
      wdog_d = wdog_q + WDW'(1);
    end

    // A fault register read clears the sticky flags, but new events win.
    if (i_fault_read) begin
      fault_d = '0;
    end

    // Address assignment marks the chain as initialized.
    if (i_addr_assigned) begin
      init_d = 1'b1;
    end

    // Mode transitions; expiry has the highest priority.
    if (wdog_expired) begin
      mode_d = mwd_pkg::MWD_FULL_PD;
      init_d = 1'b0;
      seq_d  = MWD_SEQ_IDLE;
      fault_d[mwd_pkg::FLT_WDOG_BIT] = 1'b1;
    end else begin
      case (mode_q)
        mwd_pkg::MWD_ACTIVE: begin
          // A conversion request in the same cycle wins, so no sequence runs powered down.
          if (i_partial_pd_request && seq_q == MWD_SEQ_IDLE && !i_conv_request) begin
            mode_d = mwd_pkg::MWD_PARTIAL_PD;
          end
        end
        mwd_pkg::MWD_PARTIAL_PD: begin
          if (i_wake_request || i_conv_request) begin
            mode_d = mwd_pkg::MWD_ACTIVE;
          end
        end
        default: begin
          // Full power-down wakes only on a wake command.
          if (i_wake_request) begin
            mode_d = mwd_pkg::MWD_ACTIVE;
            init_d = 1'b0;
          end
        end
      endcase
    end

    // Conversion sequence over all secondary channels.
    if (!wdog_expired) begin
      case (seq_q)
        MWD_SEQ_IDLE: begin
          // Measurements only in active mode with an initialized chain.
          if (i_conv_request && mode_q == mwd_pkg::MWD_ACTIVE && init_q) begin
            ch_d  = '0;
            seq_d = MWD_SEQ_START;
          end
        end
        MWD_SEQ_START: begin
          seq_d = MWD_SEQ_WAIT;
        end
        MWD_SEQ_WAIT: begin
          if (i_sec_done) begin
            res_d    = i_sec_data;
            res_ch_d = ch_q;
            res_v_d  = 1'b1;
            if (ch_q == 4'(CHANNELS - 1)) begin
              seq_d = MWD_SEQ_DIAG;
            end else begin
              ch_d  = ch_q + 4'h1;
              seq_d = MWD_SEQ_START;
            end
          end
        end
        default: begin
          // End of sequence: diagnostics update flags and life counter.
          fault_d[mwd_pkg::FLT_LDO_BIT]  = fault_d[mwd_pkg::FLT_LDO_BIT] |
                                           i_ldo_out_of_range;
          fault_d[mwd_pkg::FLT_FUSE_BIT] = fault_d[mwd_pkg::FLT_FUSE_BIT] | i_fuse_crc_bad;
          fault_d[mwd_pkg::FLT_DCM_BIT]  = fault_d[mwd_pkg::FLT_DCM_BIT]  | i_chain_cm_bad;
          fault_d[mwd_pkg::FLT_CFG_BIT]  = fault_d[mwd_pkg::FLT_CFG_BIT]  | i_test_mode;
          fault_d[mwd_pkg::FLT_OSC_BIT]  = fault_d[mwd_pkg::FLT_OSC_BIT]  | i_osc_drift;
          life_d = life_q + mwd_pkg::LIFE_BITS'(1);
          seq_d  = MWD_SEQ_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State registers.

  // Registers all state; the clock enable freezes everything.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      mode_q   <= mwd_pkg::MWD_ACTIVE;
      seq_q    <= MWD_SEQ_IDLE;
      wdog_q   <= '0;
      init_q   <= 1'b0;
      fault_q  <= mwd_pkg::FAULT_RESET_VALUE;
      life_q   <= '0;
      ch_q     <= '0;
      res_q    <= '0;
      res_ch_q <= '0;
      res_v_q  <= 1'b0;
    end else if (i_clk_en) begin
      mode_q   <= mode_d;
      seq_q    <= seq_d;
      wdog_q   <= wdog_d;
      init_q   <= init_d;
      fault_q  <= fault_d;
      life_q   <= life_d;
      ch_q     <= ch_d;
      res_q    <= res_d;
      res_ch_q <= res_ch_d;
      res_v_q  <= res_v_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs; all status goes to the master's serial front end only.

  assign o_sec_start        = (seq_q == MWD_SEQ_START);
  assign o_sec_channel      = ch_q;
  assign o_mode             = mode_q;
  assign o_initialized      = init_q;
  assign o_busy             = (seq_q != MWD_SEQ_IDLE);
  assign o_fault_reg        = fault_q;
  assign o_life_count       = life_q;
  assign o_sec_result       = res_q;
  assign o_sec_result_ch    = res_ch_q;
  assign o_sec_result_valid = res_v_q;

endmodule

//--- dv/mwd_props.sv
// Purpose: Port assertions for the mode and watchdog sequencer.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   A shadow count follows the watchdog from reset and service.
`timescale 1ns/1ns
module mwd_props #(
  parameter int unsigned WDOG_CYCLES = 50
) (
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic       i_clk_en,
  input wire logic       i_wdog_service,
  input wire logic       i_conv_request,
  input wire logic       i_wake_request,
  input wire logic       i_fault_read,
  input wire logic       i_sec_done,
  input wire logic       o_sec_start,
  input wire logic [3:0] o_sec_channel,
  input wire logic [1:0] o_mode,
  input wire logic       o_initialized,
  input wire logic       o_busy,
  input wire logic [7:0] o_fault_reg,
  input wire logic [2:0] o_life_count,
  input wire logic       o_sec_result_valid
);
  default clocking @(posedge i_clock); endclocking
  logic        rst_n_q; // Reset level as the design took it at the last edge.
  logic [31:0] wd_q;
  logic [31:0] wd_d;
  // The design leaves reset one edge after the bench lifts it, so both levels are watched.
  always_ff @(posedge i_clock) begin
    rst_n_q <= i_rst_n;
  end
  default disable iff (!i_rst_n || !rst_n_q);
  // Shadow count: cleared by service and held at zero while powered down.
  always_comb begin
    wd_d = wd_q;
    if (i_clk_en) begin
      wd_d = (i_wdog_service || o_mode == 2'h2) ? 32'h0 : wd_q + 32'h1;
    end
  end
  always_ff @(posedge i_clock) begin
    wd_q <= i_rst_n ? wd_d : 32'h0;
  end
  a_measure_active: assert property (
    o_busy |-> o_mode == 2'h0) else $error("sequencer busy outside active mode");
  a_wdog_expiry: assert property (
    o_mode != 2'h2 && i_clk_en |=> (o_mode == 2'h2) ==
    ($past(wd_q) == WDOG_CYCLES - 1 && !$past(i_wdog_service)))
    else $error("power-down not at the watchdog limit");
  a_expiry_flag: assert property (
    o_mode != 2'h2 ##1 o_mode == 2'h2 |-> o_fault_reg[6] && !o_initialized)
    else $error("power-down without expiry flag");
  a_wake_reinit: assert property (
    o_mode == 2'h2 && i_wake_request && i_clk_en |=> o_mode == 2'h0 && !o_initialized)
    else $error("wake from power-down kept chain state");
  a_conv_start: assert property (
    i_conv_request && i_clk_en && o_mode == 2'h0 && o_initialized && !o_busy &&
    wd_q != WDOG_CYCLES - 1
    |=> o_sec_start && o_sec_channel == 4'h0 && o_busy) else $error("sequence did not start");
  a_start_once: assert property (
    o_sec_start && i_clk_en |=> !o_sec_start) else $error("start held too long");
  a_result_pulse: assert property (
    (o_busy && !o_sec_start && !o_sec_result_valid && i_sec_done && i_clk_en &&
     wd_q != WDOG_CYCLES - 1) ##1 i_clk_en
    |-> o_sec_result_valid ##1 !o_sec_result_valid)
    else $error("result strobe wrong");
  a_life_step: assert property (
    $changed(o_life_count) |-> o_life_count == $past(o_life_count) + 3'h1)
    else $error("life count jumped");
  a_fault_clear: assert property (
    i_fault_read && i_clk_en && !o_busy && o_mode != 2'h2 && wd_q != WDOG_CYCLES - 1
    |=> o_fault_reg == 8'h00) else $error("fault read did not clear");
endmodule

//--- dv/mwd_adc_model.sv
// Purpose: Behavioural secondary converter answering start strobes.
// Assumes: Latency of one or more cycles, set by the bench.
// Notes:   Data toggles every cycle outside the done strobe.
`timescale 1ns/1ns
module mwd_adc_model (
  input  wire logic       i_clock,
  input  wire logic       i_start,
  input  wire logic [3:0] i_channel,
  input  wire logic [3:0] i_latency,
  output logic            o_done,
  output logic [9:0]      o_data
);
  logic [3:0] cnt_q = 4'h0;
  logic [3:0] ch_q  = 4'h0;
  initial o_done = 1'b0;
  initial o_data = 10'h000;
  // Ten-bit result tagged with the channel so order slips show up.
  always @(posedge i_clock) begin
    o_done <= 1'b0;
    o_data <= ~o_data;
    if (i_start) begin
      ch_q  <= i_channel;
      cnt_q <= i_latency;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h1) begin
        o_done <= 1'b1;
        o_data <= {ch_q, 6'h2B};
      end
    end
  end
endmodule

//--- dv/mwd_sequencer_tb.sv
// Purpose: Self-checking bench for the mode and watchdog sequencer.
// Assumes: Short watchdog parameter so expiry fits the run.
// Notes:   Row table runs conversions; mode tests follow by hand.
`timescale 1ns/1ns
module mwd_sequencer_tb;
  localparam int unsigned WD = 400;
  typedef struct packed {logic [3:0] lat; logic [4:0] diag; logic [7:0] flt;} mwd_row_type;
  localparam mwd_row_type ROWS [3] = '{'{4'h1, 5'h00, 8'h00}, '{4'h3, 5'h15, 8'h25},
                                       '{4'h7, 5'h0A, 8'h0A}};
  logic i_clock = 1'b0, i_rst_n = 1'b0, en = 1'b1, done, st, init, busy, rv;
  logic [5:0] cmd = 6'h00;
  logic [4:0] diag = 5'h00;
  logic [3:0] lat = 4'h1, ch, rch;
  logic [9:0] sd, res;
  logic [1:0] mode;
  logic [7:0] flt;
  logic [2:0] life;
  int mismatches = 0, n_compared = 0, cyc = 0;
  initial forever #2 i_clock = ~i_clock;
  mwd_sequencer #(.WDOG_CYCLES(WD)) i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_clk_en(en), .i_wdog_service(cmd[0]), .i_addr_assigned(cmd[1]),
    .i_conv_request(cmd[2]), .i_partial_pd_request(cmd[3]), .i_wake_request(cmd[4]),
    .i_fault_read(cmd[5]), .o_sec_start(st), .o_sec_channel(ch), .i_sec_done(done),
    .i_sec_data(sd), .i_ldo_out_of_range(diag[4]), .i_fuse_crc_bad(diag[3]),
    .i_chain_cm_bad(diag[2]), .i_test_mode(diag[1]), .i_osc_drift(diag[0]), .o_mode(mode),
    .o_initialized(init), .o_busy(busy), .o_fault_reg(flt), .o_life_count(life),
    .o_sec_result(res), .o_sec_result_ch(rch), .o_sec_result_valid(rv));
  mwd_adc_model i_adc (.i_clock(i_clock), .i_start(st), .i_channel(ch), .i_latency(lat),
    .o_done(done), .o_data(sd));
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle command pulse, then settle to mid-cycle for sampling.
  task automatic pulse(input logic [5:0] c);
    @(posedge i_clock) cmd <= c;
    @(posedge i_clock) cmd <= 6'h00;
    @(negedge i_clock);
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 300 && busy !== 1'b0; k++) @(negedge i_clock);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(negedge i_clock);
    chk("fault", 10'h080, flt);
    chk("mode", 10'h000, mode);
    chk("init", 10'h000, init);
    $display("reset done");
    pulse(6'h01);
    pulse(6'h02);
    chk("init", 10'h001, init);
    pulse(6'h20);
    chk("fault", 10'h000, flt);
    foreach (ROWS[i]) begin
      @(posedge i_clock) lat <= ROWS[i].lat;
      diag <= ROWS[i].diag;
      pulse(6'h04);
      for (int c = 0; c < 11; c++) begin
        for (int k = 0; k < 40 && rv !== 1'b1; k++) @(negedge i_clock);
        chk("channel", 10'(c), rch);
        chk("data", {c[3:0], 6'h2B}, res);
        @(negedge i_clock);
      end
      wait_idle();
      chk("flags", 10'(ROWS[i].flt), flt);
      chk("life", 10'(i + 1), life);
      pulse(6'h20);
      chk("fault", 10'h000, flt);
      pulse(6'h01);
      $display("row %0d done", i);
    end
    pulse(6'h05);
    pulse(6'h04);
    wait_idle();
    chk("life", 10'h004, life);
    $display("busy refusal done");
    pulse(6'h08);
    chk("mode", 10'h001, mode);
    @(posedge i_clock) en <= 1'b0;
    pulse(6'h04);
    chk("mode", 10'h001, mode);
    @(posedge i_clock) en <= 1'b1;
    pulse(6'h04);
    chk("mode", 10'h000, mode);
    chk("busy", 10'h000, busy);
    $display("partial power-down done");
    pulse(6'h01);
    repeat (WD - 20) @(negedge i_clock);
    pulse(6'h01);
    repeat (30) @(negedge i_clock);
    chk("mode", 10'h000, mode);
    repeat (WD) @(negedge i_clock);
    chk("mode", 10'h002, mode);
    chk("wdflag", 10'h001, flt[6]);
    chk("init", 10'h000, init);
    pulse(6'h04);
    chk("busy", 10'h000, busy);
    pulse(6'h10);
    chk("mode", 10'h000, mode);
    chk("init", 10'h000, init);
    pulse(6'h04);
    chk("busy", 10'h000, busy);
    pulse(6'h02);
    pulse(6'h04);
    chk("busy", 10'h001, busy);
    wait_idle();
    chk("life", 10'h005, life);
    $display("watchdog done");
    @(posedge i_clock) i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(negedge i_clock);
    chk("fault", 10'h080, flt);
    chk("life", 10'h000, life);
    chk("mode", 10'h000, mode);
    $display("mid-run reset done");
    results();
  end
endmodule
bind mwd_sequencer mwd_props #(.WDOG_CYCLES(WDOG_CYCLES)) u_props (.*);
